// File: src/rtca_pkg.sv
package rtca_pkg;
   // ------------------------------------------------------------
   // register map (byte addresses, one word per register)
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_CONTROL = 8'h00; // rtc_control image
   localparam logic [7:0] ADDR_TOD_ALARM_LOW = 8'h04; // tod_alarm_low, 16 bits
   localparam logic [7:0] ADDR_TOD_ALARM_HIGH = 8'h08; // tod_alarm_high, low 4 bits used
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0C; // sticky events, read only
   localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h10; // event enables
   localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h14; // write one to clear
   localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000; // answer to an unused address

   // ------------------------------------------------------------
   // rtc_control field positions
   // ------------------------------------------------------------
   localparam int BIT_TOD_IRQ_EN = 1;
   localparam int BIT_SUBSEC_IRQ_EN = 2;
   localparam int BIT_TOD_FLAG = 6;
   localparam int BIT_SUBSEC_FLAG = 7;
   localparam int BIT_SQW_EN = 8;
   localparam int BIT_SQW_FREQ = 9;
   localparam int BIT_MODE_LO = 10;
   localparam int BIT_OSC_READY = 13;
   localparam int BIT_OSC_DISABLE = 14;
   localparam logic [15:0] CONTROL_RESET = 16'h0000; // control bits after reset

   // ------------------------------------------------------------
   // interrupt status layout
   // ------------------------------------------------------------
   localparam int EVT_TOD = 0; // tod alarm flag rose
   localparam int EVT_SUBSEC = 1; // subsecond alarm flag rose
   localparam int EVT_OSC_READY = 2; // oscillator became ready
   localparam int EVT_COUNT = 3;

   // ------------------------------------------------------------
   // oscillator mode codes and timing
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_NOISE_IMMUNE = 2'b00,
      MODE_QUIET = 2'b01,
      MODE_QUIET_STOP_WAIT = 2'b10,
      MODE_QUIET_STOP_RUN = 2'b11
   } rtca_mode_e;

   typedef enum logic [1:0] {
      OSC_READY = 2'b11,
      OSC_STOPPED = 2'b00,
      OSC_WARMING = 2'b01
   } rtca_osc_e;

   localparam int WARMUP_MS = 250; // crystal warm-up time
   localparam int CLK_MHZ = 100;
   localparam longint WARMUP_CYCLES_L = longint'(WARMUP_MS) * 1000 * CLK_MHZ;
   localparam logic [31:0] WARMUP_CYCLES = WARMUP_CYCLES_L[31:0];

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic [31:0] seconds; // second counter value
      logic subsec_reload; // subsecond timer reloaded, one pulse
   } rtca_count_s;

   typedef struct packed {
      logic osc_quiet; // drive oscillator quiet
      logic cpu_hold; // hold cpu after stop exit
   } rtca_osc_ctl_s;
endpackage : rtca_pkg

// File: src/rtca_osc_mode.sv
`timescale 1ns/1ps
module rtca_osc_mode #(
   parameter logic [31:0] WARMUP = rtca_pkg::WARMUP_CYCLES
) (
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic [1:0] i_mode,
   input wire logic i_osc_disable,
   input wire logic i_stop_mode,
   output rtca_pkg::rtca_osc_ctl_s o_ctl,
   output logic o_ready
);
   import rtca_pkg::*;

   // ------------------------------------------------------------
   // warm-up sequencer
   // ------------------------------------------------------------
   rtca_osc_e state_q;
   logic [31:0] cnt_q;
   logic [1:0] mode_q; // previous mode, for change detect
   logic stop_q; // previous stop level
   logic quiet_now; // oscillator currently in quiet mode
   logic need_warm; // a mode change that needs warm-up

   // quiet per mode: 01 always, 10/11 only inside stop
   always_comb begin
      case (rtca_mode_e'(i_mode))
         MODE_NOISE_IMMUNE: quiet_now = 1'b0; // [R11]
         MODE_QUIET: quiet_now = 1'b1; // [R11]
         default: quiet_now = i_stop_mode; // [R12] [R13]
      endcase
   end

   // leaving quiet into noise-immune needs a warm-up
   assign need_warm = (mode_q != i_mode) && !quiet_now && !i_osc_disable; // [R14]

   // history registers
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         mode_q <= 2'b00;
         stop_q <= 1'b0;
      end else begin
         mode_q <= i_mode;
         stop_q <= i_stop_mode;
      end
   end

   // state and warm-up counter
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         state_q <= OSC_WARMING;
         cnt_q <= 32'h0000_0000;
      end else if (i_osc_disable) begin
         state_q <= OSC_STOPPED; // no 32k source at all
         cnt_q <= 32'h0000_0000;
      end else begin
         case (state_q)
            OSC_STOPPED: begin
               state_q <= OSC_WARMING;
               cnt_q <= 32'h0000_0000;
            end
            OSC_WARMING: begin
               if (need_warm || (stop_q && !i_stop_mode && !quiet_now)) begin
                  cnt_q <= 32'h0000_0000; // restart on a fresh change
               end else if (cnt_q >= WARMUP - 32'd1) begin
                  state_q <= OSC_READY; // [R16]
               end else begin
                  cnt_q <= cnt_q + 32'd1;
               end
            end
            default: begin
               // stop exit back to noise immune also warms up
               if (need_warm || (stop_q && !i_stop_mode && i_mode[1])) begin
                  state_q <= OSC_WARMING; // [R14]
                  cnt_q <= 32'h0000_0000;
               end
            end
         endcase
      end
   end

   assign o_ready = (state_q == OSC_READY) && !need_warm; // [R14] [R16]
   assign o_ctl.osc_quiet = quiet_now;
   // code 10 holds the cpu through warm-up; code 11 lets it run
   assign o_ctl.cpu_hold = (i_mode == MODE_QUIET_STOP_WAIT) && !i_stop_mode
      && (state_q != OSC_READY); // [R12] [R13]
endmodule : rtca_osc_mode

// File: src/rtca_top.sv
`timescale 1ns/1ps
// Functional notes
// R01: seconds equal 20-bit alarm sets tod flag
// R02: tod irq needs enable and system permit
// R03: alarm flags stay set until software clears
// R04: unmasked tod alarm wakes from stop
// R05: subsecond reload sets subsecond flag
// R06: subsec irq needs enable and system permit
// R07: unmasked subsecond alarm wakes from stop
// R08: enable routes selected tap, else undriven; when off, the pin carries i_tdo and its enable follows i_tdo_en
// R09: square wave beats debug output on pin
// R10: freq select 1 is 512Hz, 0 is 1Hz
// R11: mode 00 noise-immune, 01 quiet always
// R12: mode 10 quiet in stop, cpu waits
// R13: mode 11 quiet in stop, cpu runs
// R14: warm-up mode change clears ready bit
// R15: enable bits gate each alarm interrupt
// R16: ready set once oscillator warmed up
// R17: one level wake request from both alarms
module rtca_top #(
   parameter logic [31:0] WARMUP_CYCLES_P = rtca_pkg::WARMUP_CYCLES
) (
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   // avalon-mm slave
   input wire logic [7:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // neighbouring rtc logic, same clock
   input wire rtca_pkg::rtca_count_s i_count,
   input wire logic i_tap_1hz,
   input wire logic i_tap_512hz,
   input wire logic i_sys_irq_allow,
   input wire logic i_stop_mode,
   // shared port pin
   input wire logic i_tdo_en,
   input wire logic i_tdo,
   output logic o_square_wave_pin,
   output logic o_square_wave_pin_oe,
   // cpu and power manager
   output logic o_alarm_irq,
   output logic o_wake_req,
   output logic o_osc_quiet,
   output logic o_cpu_hold,
   output logic o_irq
);
   import rtca_pkg::*;

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic tod_alarm_flag_q; // sticky tod alarm
   logic subsec_alarm_flag_q; // sticky subsecond alarm
   logic tod_alarm_irq_en_q;
   logic subsec_alarm_irq_en_q;
   logic square_wave_out_en_q;
   logic square_wave_freq_sel_q;
   logic [1:0] osc_mode_field_q;
   logic slow_osc_input_disable_q;
   logic [15:0] tod_alarm_low_q;
   logic [3:0] tod_alarm_high_q;

   logic [EVT_COUNT-1:0] irq_status_q;
   logic [EVT_COUNT-1:0] irq_enable_q;

   logic ack_q; // one-cycle wait before answer
   logic [31:0] readdata_q;
   logic ready_q; // registered ready for edge detect
   logic match_q; // previous match, so a long match sets once

   logic osc_ready; // from the sequencer
   rtca_osc_ctl_s osc_ctl;

   logic [15:0] control_img; // rtc_control as read
   logic [19:0] alarm_value;
   logic tod_match;
   logic wr_ctl;
   logic wr_en_lo; // low byte lane of the word
   logic wr_en_hi; // second byte lane
   logic [EVT_COUNT-1:0] events;

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   // true when the access targets the given register
   function automatic logic hit(input logic [7:0] addr, input logic [7:0] reg_addr);
      hit = (addr == reg_addr);
   endfunction : hit

   // access is accepted one cycle after it appears
   assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_q;
   assign wr_ctl = i_avs_write && ack_q && hit(i_avs_address, ADDR_CONTROL);
   assign wr_en_lo = i_avs_byteenable[0];
   assign wr_en_hi = i_avs_byteenable[1];

   // handshake register
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (i_avs_read || i_avs_write) && !ack_q;
      end
   end

   // ------------------------------------------------------------
   // control and alarm registers
   // ------------------------------------------------------------
   // software-written control bits
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         tod_alarm_irq_en_q <= CONTROL_RESET[BIT_TOD_IRQ_EN];
         subsec_alarm_irq_en_q <= CONTROL_RESET[BIT_SUBSEC_IRQ_EN];
         square_wave_out_en_q <= CONTROL_RESET[BIT_SQW_EN];
         square_wave_freq_sel_q <= CONTROL_RESET[BIT_SQW_FREQ];
         osc_mode_field_q <= CONTROL_RESET[BIT_MODE_LO +: 2];
         slow_osc_input_disable_q <= CONTROL_RESET[BIT_OSC_DISABLE];
      end else if (wr_ctl) begin
         if (wr_en_lo) begin
            tod_alarm_irq_en_q <= i_avs_writedata[BIT_TOD_IRQ_EN];
            subsec_alarm_irq_en_q <= i_avs_writedata[BIT_SUBSEC_IRQ_EN];
         end
         if (wr_en_hi) begin
            square_wave_out_en_q <= i_avs_writedata[BIT_SQW_EN];
            square_wave_freq_sel_q <= i_avs_writedata[BIT_SQW_FREQ];
            osc_mode_field_q <= i_avs_writedata[BIT_MODE_LO +: 2];
            slow_osc_input_disable_q <= i_avs_writedata[BIT_OSC_DISABLE];
         end
      end
   end

   // 20-bit time-of-day alarm value
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         tod_alarm_low_q <= 16'h0000;
         tod_alarm_high_q <= 4'h0;
      end else if (i_avs_write && ack_q) begin
         if (hit(i_avs_address, ADDR_TOD_ALARM_LOW)) begin
            if (wr_en_lo) tod_alarm_low_q[7:0] <= i_avs_writedata[7:0];
            if (wr_en_hi) tod_alarm_low_q[15:8] <= i_avs_writedata[15:8];
         end else if (hit(i_avs_address, ADDR_TOD_ALARM_HIGH) && wr_en_lo) begin
            tod_alarm_high_q <= i_avs_writedata[3:0];
         end
      end
   end

   // ------------------------------------------------------------
   // alarm flags
   // ------------------------------------------------------------
   assign alarm_value = {tod_alarm_high_q, tod_alarm_low_q};
   // only the low 20 bits of the seconds counter take part
   assign tod_match = (i_count.seconds[19:0] == alarm_value); // [R01]

   // match history
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         match_q <= 1'b0;
      end else begin
         match_q <= tod_match;
      end
   end

   // flags: hardware sets, only software writing zero clears; set wins
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         tod_alarm_flag_q <= 1'b0;
         subsec_alarm_flag_q <= 1'b0;
      end else begin
         if (tod_match && !match_q) begin
            tod_alarm_flag_q <= 1'b1; // [R01]
         end else if (wr_ctl && wr_en_lo && !i_avs_writedata[BIT_TOD_FLAG]) begin
            tod_alarm_flag_q <= 1'b0; // [R03]
         end
         if (i_count.subsec_reload) begin
            subsec_alarm_flag_q <= 1'b1; // [R05]
         end else if (wr_ctl && wr_en_lo && !i_avs_writedata[BIT_SUBSEC_FLAG]) begin
            subsec_alarm_flag_q <= 1'b0; // [R03]
         end
      end
   end

   // level requests, gated by enables; the alarm irq also by system permit
   assign o_alarm_irq = i_sys_irq_allow && ((tod_alarm_flag_q && tod_alarm_irq_en_q) // [R02] [R15]
      || (subsec_alarm_flag_q && subsec_alarm_irq_en_q)); // [R06] [R15]
   // wake ignores the system permit: stop exit needs only the local mask
   assign o_wake_req = (tod_alarm_flag_q && tod_alarm_irq_en_q) // [R04] [R17]
      || (subsec_alarm_flag_q && subsec_alarm_irq_en_q); // [R07] [R17]

   // ------------------------------------------------------------
   // square wave pin
   // ------------------------------------------------------------
   // registered so the pin carries no decode glitches
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         o_square_wave_pin <= 1'b0;
         o_square_wave_pin_oe <= 1'b0;
      end else if (square_wave_out_en_q) begin
         o_square_wave_pin <= square_wave_freq_sel_q ? i_tap_512hz : i_tap_1hz; // [R08] [R10]
         o_square_wave_pin_oe <= 1'b1; // [R09]
      end else begin
         o_square_wave_pin <= i_tdo; // debug output only when square wave is off
         o_square_wave_pin_oe <= i_tdo_en; // [R08] [R09]
      end
   end

   // ------------------------------------------------------------
   // oscillator mode sequencer
   // ------------------------------------------------------------
   rtca_osc_mode #(
      .WARMUP(WARMUP_CYCLES_P)
   ) u_osc (
      .i_ref_clk(i_ref_clk),
      .i_sys_rst(i_sys_rst),
      .i_mode(osc_mode_field_q),
      .i_osc_disable(slow_osc_input_disable_q),
      .i_stop_mode(i_stop_mode),
      .o_ctl(osc_ctl),
      .o_ready(osc_ready)
   );
   assign o_osc_quiet = osc_ctl.osc_quiet; // [R11]
   assign o_cpu_hold = osc_ctl.cpu_hold; // [R12] [R13]

   // ------------------------------------------------------------
   // interrupt status, enable and clear
   // ------------------------------------------------------------
   // ready history
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         ready_q <= 1'b0;
      end else begin
         ready_q <= osc_ready;
      end
   end

   assign events[EVT_TOD] = tod_match && !match_q;
   assign events[EVT_SUBSEC] = i_count.subsec_reload;
   assign events[EVT_OSC_READY] = osc_ready && !ready_q;

   // sticky status; a new event beats a simultaneous clear
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         irq_status_q <= '0;
         irq_enable_q <= '0;
      end else begin
         for (int i = 0; i < EVT_COUNT; i++) begin
            if (events[i]) begin
               irq_status_q[i] <= 1'b1;
            end else if (i_avs_write && ack_q && hit(i_avs_address, ADDR_IRQ_CLEAR)
                         && wr_en_lo && i_avs_writedata[i]) begin
               irq_status_q[i] <= 1'b0;
            end
         end
         if (i_avs_write && ack_q && hit(i_avs_address, ADDR_IRQ_ENABLE) && wr_en_lo) begin
            irq_enable_q <= i_avs_writedata[EVT_COUNT-1:0];
         end
      end
   end

   assign o_irq = |(irq_status_q & irq_enable_q);

   // ------------------------------------------------------------
   // read path
   // ------------------------------------------------------------
   always_comb begin
      control_img = 16'h0000;
      control_img[BIT_TOD_IRQ_EN] = tod_alarm_irq_en_q;
      control_img[BIT_SUBSEC_IRQ_EN] = subsec_alarm_irq_en_q;
      control_img[BIT_TOD_FLAG] = tod_alarm_flag_q;
      control_img[BIT_SUBSEC_FLAG] = subsec_alarm_flag_q;
      control_img[BIT_SQW_EN] = square_wave_out_en_q;
      control_img[BIT_SQW_FREQ] = square_wave_freq_sel_q;
      control_img[BIT_MODE_LO +: 2] = osc_mode_field_q;
      control_img[BIT_OSC_READY] = osc_ready; // [R16]
      control_img[BIT_OSC_DISABLE] = slow_osc_input_disable_q;
   end

   // data captured on the wait-state edge, one edge before the accepting edge
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         readdata_q <= 32'h0000_0000;
      end else if (i_avs_read && !ack_q) begin
         if (hit(i_avs_address, ADDR_CONTROL)) begin
            readdata_q <= {16'h0000, control_img};
         end else if (hit(i_avs_address, ADDR_TOD_ALARM_LOW)) begin
            readdata_q <= {16'h0000, tod_alarm_low_q};
         end else if (hit(i_avs_address, ADDR_TOD_ALARM_HIGH)) begin
            readdata_q <= {28'h0000000, tod_alarm_high_q};
         end else if (hit(i_avs_address, ADDR_IRQ_STATUS)) begin
            readdata_q <= {29'h00000000, irq_status_q};
         end else if (hit(i_avs_address, ADDR_IRQ_ENABLE)) begin
            readdata_q <= {29'h00000000, irq_enable_q};
         end else begin
            readdata_q <= UNMAPPED_READ; // clear register and holes read zero
         end
      end
   end

   assign o_avs_readdata = readdata_q;
endmodule : rtca_top

// File: testbench/rtca_pm_model.sv
`timescale 1ns/1ps
// ------------
// stop-mode power manager
// ------------
module rtca_pm_model (
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic i_go_stop,
   input wire logic [3:0] i_wake_dly,
   input wire logic i_wake_req,
   output logic o_stop_mode
);
   logic [3:0] wait_q; // cycles left before leaving stop
   // enter on command, leave on a wake level after the latency
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         o_stop_mode <= 1'b0;
         wait_q <= 4'h0;
      end else if (!o_stop_mode) begin
         o_stop_mode <= i_go_stop;
         wait_q <= i_wake_dly;
      end else if (i_wake_req && wait_q == 4'h0) begin
         o_stop_mode <= 1'b0;
      end else if (i_wake_req) begin
         wait_q <= wait_q - 4'h1;
      end
   end
endmodule : rtca_pm_model

// File: testbench/rtca_top_properties.sv
`timescale 1ns/1ps
module rtca_chk import rtca_pkg::*; (
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic [7:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   input wire logic o_avs_waitrequest,
   input wire rtca_pkg::rtca_count_s i_count,
   input wire logic i_tap_1hz,
   input wire logic i_tap_512hz,
   input wire logic i_sys_irq_allow,
   input wire logic i_stop_mode,
   input wire logic i_tdo_en,
   input wire logic o_square_wave_pin,
   input wire logic o_square_wave_pin_oe,
   input wire logic o_alarm_irq,
   input wire logic o_wake_req,
   input wire logic o_osc_quiet,
   input wire logic o_cpu_hold
);
   logic [7:0] ctl_q; // upper control byte
   // ------------
   // control shadow
   // ------------
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         ctl_q <= 8'h00;
      end else if (i_avs_write && !o_avs_waitrequest && i_avs_address == ADDR_CONTROL
                   && i_avs_byteenable[1]) begin
         ctl_q <= i_avs_writedata[15:8];
      end
   end
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_sys_rst);
   a_irq_from_wake: assert property (o_alarm_irq == (o_wake_req && i_sys_irq_allow))
      else $error("irq gating");
   a_wake_held: assert property ($fell(o_wake_req) |-> $past(i_avs_write))
      else $error("wake fell");
   a_wake_cause: assert property ($rose(o_wake_req) |-> $past(i_avs_write) ||
      $past(i_count.subsec_reload) || $past(i_count.subsec_reload, 2) ||
      ($past(i_count.seconds) != $past(i_count.seconds, 3)))
      else $error("wake rose");
   a_bus_wait: assert property ((i_avs_read || i_avs_write) && !$past(i_avs_read) &&
      !$past(i_avs_write) |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
      else $error("wait state");
   a_quiet_in_stop: assert property (i_stop_mode && $past(i_stop_mode) |->
      o_osc_quiet == (ctl_q[3:2] != 2'b00))
      else $error("stop quiet");
   a_fixed_modes: assert property (!i_stop_mode && !ctl_q[3] && $stable(ctl_q[3:2]) |->
      o_osc_quiet == ctl_q[2])
      else $error("fixed quiet");
   a_hold_mode: assert property (o_cpu_hold |-> ctl_q[3:2] == 2'b10 && !i_stop_mode)
      else $error("stray hold");
   a_hold_on_exit: assert property ($fell(i_stop_mode) && ctl_q[3:2] == 2'b10 |->
      ##[0:2] o_cpu_hold)
      else $error("no hold");
   a_pin_routing: assert property (ctl_q[0] && $stable(ctl_q[1:0]) |->
      o_square_wave_pin_oe && o_square_wave_pin == $past(ctl_q[1] ? i_tap_512hz : i_tap_1hz))
      else $error("tap routing");
   a_pin_release: assert property (!ctl_q[0] && $stable(ctl_q[0]) && !$past(i_sys_rst) |->
      o_square_wave_pin_oe == $past(i_tdo_en))
      else $error("pin release");
endmodule : rtca_chk
bind rtca_top rtca_chk chk_u (.i_ref_clk, .i_sys_rst, .i_avs_address, .i_avs_read,
   .i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_waitrequest, .i_count,
   .i_tap_1hz, .i_tap_512hz, .i_sys_irq_allow, .i_stop_mode, .i_tdo_en,
   .o_square_wave_pin, .o_square_wave_pin_oe, .o_alarm_irq, .o_wake_req, .o_osc_quiet,
   .o_cpu_hold);

// File: testbench/tb.sv
`timescale 1ns/1ps
module tb;
   import rtca_pkg::*;
   typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e;} rtca_row_s;
   logic clk, rst, rd, wr, t1, t512, tdo_en, tdo, allow, go_stop, wreq, pin, pin_oe;
   logic airq, wake, quiet, hold, irq, stop_w;
   logic [7:0] adr;
   logic [31:0] wdat, rdat, q, cv;
   logic [3:0] dly; // partner wake latency
   rtca_count_s cnt;
   int n_mismatch = 0;
   int n_checks = 0;
   // write value and readback; ready bit set once warm
   rtca_row_s rows [8] = '{'{8'h04, 32'h1234, 32'h1234}, '{8'h08, 32'h5, 32'h5},
      '{8'h10, 32'h3, 32'h3}, '{8'h0C, 32'hFF, 32'h4}, '{8'h14, 32'h4, 32'h0},
      '{8'h0C, 32'h0, 32'h0}, '{8'h20, 32'hFFFF, 32'h0}, '{8'h00, 32'h0306, 32'h2306}};
   rtca_top #(.WARMUP_CYCLES_P(32'd20)) dut_u (.i_ref_clk(clk), .i_sys_rst(rst),
      .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
      .i_avs_byteenable(4'hF), .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .i_count(cnt),
      .i_tap_1hz(t1), .i_tap_512hz(t512), .i_sys_irq_allow(allow), .i_stop_mode(stop_w),
      .i_tdo_en(tdo_en), .i_tdo(tdo), .o_square_wave_pin(pin), .o_square_wave_pin_oe(pin_oe),
      .o_alarm_irq(airq), .o_wake_req(wake), .o_osc_quiet(quiet), .o_cpu_hold(hold), .o_irq(irq));
   rtca_pm_model pm_u (.i_ref_clk(clk), .i_sys_rst(rst), .i_go_stop(go_stop),
      .i_wake_dly(dly), .i_wake_req(wake), .o_stop_mode(stop_w));
   // ------------
   // helpers
   // ------------
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_bit(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask : chk_bit
   // avalon cycle, held until waitrequest samples low at a rising edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      int n = 0;
      @(posedge clk);
      {wr, rd, adr, wdat} <= {w, !w, a, d};
      do begin
         @(posedge clk);
         n++;
      end while (wreq !== 1'b0 && n < 40);
      if (n >= 40) n_mismatch++;
      r = rdat;
      {wr, rd} <= 2'b00;
      @(negedge clk);
   endtask : bus
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask : settle
   task automatic pulse_reload;
      @(posedge clk) cnt.subsec_reload <= 1'b1;
      @(posedge clk) cnt.subsec_reload <= 1'b0;
   endtask : pulse_reload
   // bounded poll of the ready bit
   task automatic wait_ready;
      repeat (40) begin
         bus(1'b0, ADDR_CONTROL, 32'h0, q);
         if (q[13] === 1'b1) break;
      end
   endtask : wait_ready
   // ------------
   // clock, watchdog, main sequence
   // ------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      repeat (8000) @(posedge clk);
      n_mismatch++;
      tally_and_finish();
   end
   initial begin
      {rst, rd, wr, t1, t512, tdo_en, tdo, allow, go_stop} = 9'h100;
      adr = 8'h00;
      wdat = 32'h0;
      dly = 4'h0;
      cnt = '{seconds: 32'hFFFF_FFFF, subsec_reload: 1'b0}; // away from reset alarm
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      settle(30);
      foreach (rows[i]) begin
         bus(1'b1, rows[i].a, rows[i].d, q);
         bus(1'b0, rows[i].a, 32'h0, q);
         chk(q, rows[i].e);
      end
      // time-of-day match on low 20 bits, upper bits differ
      @(posedge clk) allow <= 1'b1;
      @(posedge clk) cnt.seconds <= 32'hABC5_1233;
      settle(2);
      chk_bit(wake, 1'b0);
      @(posedge clk) cnt.seconds <= 32'hABC5_1234;
      settle(3);
      chk_bit(airq, 1'b1);
      chk_bit(irq, 1'b1);
      @(posedge clk) allow <= 1'b0;
      settle(20);
      chk_bit(airq, 1'b0);
      chk_bit(wake, 1'b1);
      bus(1'b0, ADDR_CONTROL, 32'h0, q);
      chk(q, 32'h2346);
      bus(1'b1, ADDR_IRQ_ENABLE, 32'h0, q);
      chk_bit(irq, 1'b0);
      bus(1'b1, ADDR_IRQ_ENABLE, 32'h3, q);
      chk_bit(irq, 1'b1);
      bus(1'b1, ADDR_IRQ_CLEAR, 32'h1, q);
      chk_bit(irq, 1'b0);
      bus(1'b1, ADDR_CONTROL, 32'h0306, q);
      chk_bit(wake, 1'b0);
      // subsecond flag with its enable off, then on
      @(posedge clk) allow <= 1'b1;
      bus(1'b1, ADDR_CONTROL, 32'h0302, q);
      pulse_reload();
      settle(2);
      chk_bit(wake, 1'b0);
      bus(1'b0, ADDR_CONTROL, 32'h0, q);
      chk(q, 32'h2382);
      bus(1'b1, ADDR_CONTROL, 32'h0386, q);
      chk_bit(airq, 1'b1);
      chk_bit(wake, 1'b1);
      bus(1'b1, ADDR_CONTROL, 32'h0306, q);
      // stop and wake, modes 11 and 10 (slow partner)
      for (int m = 3; m >= 2; m--) begin
         cv = 32'h0306 | (m << 10);
         bus(1'b1, ADDR_CONTROL, cv, q);
         wait_ready();
         @(posedge clk) dly <= (m == 2) ? 4'h5 : 4'h0;
         @(posedge clk) go_stop <= 1'b1;
         @(posedge clk) go_stop <= 1'b0;
         settle(2);
         chk_bit(quiet, 1'b1);
         pulse_reload();
         repeat (20) if (stop_w !== 1'b0) @(posedge clk);
         settle(1);
         chk_bit(stop_w, 1'b0);
         chk_bit(hold, m == 2);
         bus(1'b0, ADDR_CONTROL, 32'h0, q);
         chk(q & 32'h2000, 32'h0);
         wait_ready();
         chk_bit(hold, 1'b0);
         bus(1'b1, ADDR_CONTROL, cv, q);
      end
      // fixed modes, then back to noise-immune drops ready
      for (int m = 1; m >= 0; m--) begin
         bus(1'b1, ADDR_CONTROL, 32'h0306 | (m << 10), q);
         settle(2);
         chk_bit(quiet, m == 1);
      end
      bus(1'b0, ADDR_CONTROL, 32'h0, q);
      chk(q & 32'h2000, 32'h0);
      // taps against the debug output, set opposite
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, ADDR_CONTROL, 32'h0106 | (i[0] << 9), q);
         @(posedge clk) {t1, t512, tdo, tdo_en} <= {i[1], !i[1], i[0] ~^ i[1], 1'b1};
         settle(2);
         chk_bit(pin, i[0] ^ i[1]);
         chk_bit(pin_oe, 1'b1);
      end
      bus(1'b1, ADDR_CONTROL, 32'h0006, q);
      @(posedge clk) tdo <= 1'b1;
      settle(2);
      chk_bit(pin, 1'b1);
      @(posedge clk) tdo_en <= 1'b0;
      settle(2);
      chk_bit(pin_oe, 1'b0);
      bus(1'b1, ADDR_CONTROL, 32'h4006, q);
      bus(1'b0, ADDR_CONTROL, 32'h0, q);
      chk(q, 32'h4006);
      // mid-run reset clears control, restarts warm-up
      @(posedge clk) rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      bus(1'b0, ADDR_CONTROL, 32'h0, q);
      chk(q, 32'h0);
      tally_and_finish();
   end
endmodule : tb
